// ### verilog/pcs_defs.svh
// Operation
// R1: System clock divides the 8 MHz oscillator to eight rates, 8 MHz down to 62.5 kHz.
// R2: Every reset restores the 500 kHz divider setting until software changes it.
// R3: The 32.768 kHz timer oscillator drives the power manager and cannot be disabled.
// R4: One gate bit per peripheral or memory passes or blocks the system clock.
// R5: Temperature sensor gets a fixed clock independent of the system clock divider.
// R6: Reset sources are the reset pin, a watchdog request and a software request.
// R7: Battery switch stays open until a reset pin rising edge or field power.
// R8: Battery above 1.72 V feeds the always-on rail and wins over the field.
// R9: Battery at or below 1.72 V with field present powers domains from field.
// R10: Losing the battery moves power to the field at once; switching back allowed.
// R11: Software can disable automatic selection, turning off the comparator and forcing battery.
// R12: Without field power the power manager may open the battery switch: battery off.
// R13: Active has both flags low; deep power-down flag or sleep flag otherwise.
// R14: With brownout detection enabled, always-on rail below 1.8 V raises brownout interrupt.
// R15: Power-up machine first enables the digital regulator, then the analog regulator.
// R16: Digital reset releases with regulator on and oscillator stable; boot waits for flash.
// R17: Start-up from trigger to boot takes about 2.5 ms.
// R18: Field-only power follows the same start-up with the field switch feeding regulators.
// R19: Deep sleep wakes on reset pin, timer, watchdog, wake pin, field or start logic.
// R20: Deep power-down wakes only on reset pin, timer, enabled wake pin or field.
// R21: Digital and analog regulators have separate enables.
// R22: The configuration block holds an interrupt vector table remap register.
// R23: The far side holds the wake pin high before, then low 100 us to leave.
// R24: Five retention registers in the always-on domain survive deep power-down.
// R25: A divider change takes effect without a shortened system clock pulse.
// R26: Every reset restores divider, clock gates and power flags before execution starts.
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH
`define PCS_OSC_HZ         8000000
`define PCS_TMR_HZ         32768
`define PCS_STARTUP_US     2500
`define PCS_STARTUP_TICKS  ((`PCS_STARTUP_US * `PCS_TMR_HZ) / 1000000)
`define PCS_DREG_TICKS     (`PCS_STARTUP_TICKS / 2)
`define PCS_TS_LAST        3'h7
`define PCS_DIV_RESET      3'h4
`define PCS_GATE_RESET     16'h001f
`define PCS_OFS_DIV        8'h00
`define PCS_OFS_GATE       8'h04
`define PCS_OFS_PCTL       8'h08
`define PCS_OFS_STAT       8'h0c
`define PCS_OFS_SWRST      8'h10
`define PCS_OFS_REMAP      8'h14
`define PCS_OFS_RET0       8'h20
`define PCS_RET_WORDS      5
`define PCS_B_SLEEP        0
`define PCS_B_DPD          1
`define PCS_B_BOFF         2
`define PCS_B_AUTODIS      3
`define PCS_B_BODEN        4
`define PCS_B_WAKEEN       5
`define PCS_B_FLDEN        6
`define PCS_REQ_MASK       8'h07
`endif

// ### verilog/pcs_pkg.sv
package pcs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_DREG   = 3'h1,
    ST_AREG   = 3'h3,
    ST_BOOT   = 3'h2,
    ST_ACTIVE = 3'h6,
    ST_SLEEP  = 3'h7,
    ST_DPD    = 3'h5,
    ST_OFF    = 3'h4
  } pcs_state_type;

  typedef struct packed {
    pcs_state_type     st;
    logic [6:0]        tcnt;
    logic [2:0]        div_sel;
    logic [2:0]        div_act;
    logic [6:0]        div_cnt;
    logic              sys_tick;
    logic [2:0]        ts_cnt;
    logic              ts_tick;
    logic [15:0]       gate;
    logic [7:0]        pctl;
    logic [1:0]        remap;
    logic              sw_rst;
    logic              pin_q;
    logic              bat_sw;
    logic              use_bat;
    logic              bod_irq;
    logic [31:0]       rdata;
    logic [4:0][31:0]  ret;
  } pcs_regs_type;
endpackage

// ### verilog/pcs_top.sv
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "pcs_defs.svh"
module pcs_top
  import pcs_pkg::*;
(
  // Clock and power-on reset of the always-on domain.
  input  wire logic        clock,
  input  wire logic        rstn,
  // Register port.
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Oscillator ticks and status.
  input  wire logic        osc_tick,
  input  wire logic        tmr_tick,
  input  wire logic        osc_stable,
  input  wire logic        flash_ready,
  // Reset sources.
  input  wire logic        reset_pin_active_low,
  input  wire logic        wdt_reset_req,
  // Supply monitors.
  input  wire logic        battery_ok,
  input  wire logic        field_present,
  input  wire logic        always_on_low,
  // Wake sources.
  input  wire logic        rtc_match,
  input  wire logic        wdt_event,
  input  wire logic        external_wake_pin,
  input  wire logic        start_irq,
  // Clock outputs.
  output logic             sys_tick,
  output logic      [15:0] periph_tick,
  output logic             tsens_tick,
  // Power and reset outputs.
  output logic             battery_power_switch,
  output logic             field_power_switch,
  output logic             selector_comparator_en,
  output logic             digital_regulator_en,
  output logic             analog_regulator_en,
  output logic             sys_reset_n,
  output logic             boot_enable,
  output logic             deep_power_down_flag,
  output logic             sleep_flag,
  output logic             brownout_irq,
  output logic      [1:0]  vector_remap
);

  pcs_regs_type r;
  pcs_regs_type next_r;
  logic         dig_rst;
  logic         fld_ok;
  logic         wake_ds;
  logic         wake_dpd;
  logic [6:0]   period_last;

  assign dig_rst  = ~reset_pin_active_low | wdt_reset_req | r.sw_rst; // R6
  assign fld_ok   = field_present;
  assign wake_ds  = ~reset_pin_active_low | rtc_match | wdt_event | ~external_wake_pin
                  | (field_present & r.pctl[`PCS_B_FLDEN]) | start_irq; // R19
  assign wake_dpd = ~reset_pin_active_low | rtc_match
                  | (~external_wake_pin & r.pctl[`PCS_B_WAKEEN])
                  | (field_present & r.pctl[`PCS_B_FLDEN]); // R20
  assign period_last = 7'((8'h01 << r.div_act) - 8'h01); // R1

  always_comb
  begin
    next_r          = r;
    next_r.sys_tick = 1'b0;
    next_r.ts_tick  = 1'b0;
    next_r.sw_rst   = 1'b0;
    next_r.rdata    = 32'h0000_0000;
    next_r.pin_q    = reset_pin_active_low;
    // System clock divider; a written setting is adopted only at a period boundary, the reset default at once.
    if (osc_tick)
    begin
      if (r.div_cnt == period_last)
      begin
        next_r.div_cnt  = 7'h00;
        next_r.sys_tick = 1'b1; // R1
        next_r.div_act  = r.div_sel; // R25
      end
      else
      begin
        next_r.div_cnt = r.div_cnt + 7'h01;
      end
      next_r.ts_cnt = r.ts_cnt + 3'h1;
      if (r.ts_cnt == `PCS_TS_LAST)
      begin
        next_r.ts_tick = 1'b1; // R5
      end
    end
    // Battery switch closes on a reset pin rising edge or field power.
    if ((reset_pin_active_low & ~r.pin_q) | fld_ok)
    begin
      next_r.bat_sw = 1'b1; // R7
    end
    // Source selection; forced battery when automatic selection is off.
    if (r.pctl[`PCS_B_AUTODIS])
    begin
      next_r.use_bat = 1'b1; // R11
    end
    else if (battery_ok)
    begin
      next_r.use_bat = 1'b1; // R8
    end
    else if (fld_ok)
    begin
      next_r.use_bat = 1'b0; // R9 R10
    end
    next_r.bod_irq = r.pctl[`PCS_B_BODEN] & always_on_low; // R14
    // Register writes.
    if (wr)
    begin
      unique case (addr)
        `PCS_OFS_DIV:   next_r.div_sel = wdata[2:0];
        `PCS_OFS_GATE:  next_r.gate    = wdata[15:0]; // R4
        `PCS_OFS_PCTL:  next_r.pctl    = wdata[7:0];
        `PCS_OFS_SWRST: next_r.sw_rst  = wdata[0]; // R6
        `PCS_OFS_REMAP: next_r.remap   = wdata[1:0]; // R22
        default:
        begin
          for (int i = 0; i < `PCS_RET_WORDS; i++)
          begin
            if (addr == 8'(`PCS_OFS_RET0 + 4 * i))
            begin
              next_r.ret[i] = wdata; // R24
            end
          end
        end
      endcase
    end
    // Register reads, answered in the following cycle.
    if (rd)
    begin
      unique case (addr)
        `PCS_OFS_DIV:   next_r.rdata = {29'h0000_0000, r.div_sel};
        `PCS_OFS_GATE:  next_r.rdata = {16'h0000, r.gate};
        `PCS_OFS_PCTL:  next_r.rdata = {24'h00_0000, r.pctl};
        `PCS_OFS_STAT:  next_r.rdata = {20'h0_0000, r.bod_irq, r.use_bat, r.bat_sw,
                                        osc_stable, r.div_act, deep_power_down_flag,
                                        sleep_flag, r.st};
        `PCS_OFS_REMAP: next_r.rdata = {30'h0000_0000, r.remap};
        default:
        begin
          for (int i = 0; i < `PCS_RET_WORDS; i++)
          begin
            if (addr == 8'(`PCS_OFS_RET0 + 4 * i))
            begin
              next_r.rdata = r.ret[i];
            end
          end
        end
      endcase
    end
    // Power-up and power-state machine; the idle and regulator steps are paced by the timer oscillator.
    unique case (r.st)
      ST_IDLE:
      begin
        next_r.tcnt = 7'h00;
        if (tmr_tick & (r.bat_sw | fld_ok)) // R3 R18
        begin
          next_r.st = ST_DREG; // R15
        end
      end
      ST_DREG:
      begin
        if (tmr_tick)
        begin
          next_r.tcnt = r.tcnt + 7'h01;
          if (r.tcnt == 7'(`PCS_DREG_TICKS))
          begin
            next_r.st = ST_AREG; // R15
          end
        end
      end
      ST_AREG:
      begin
        if (tmr_tick)
        begin
          next_r.tcnt = r.tcnt + 7'h01;
          if (r.tcnt == 7'(`PCS_STARTUP_TICKS))
          begin
            next_r.st = ST_BOOT; // R17
          end
        end
      end
      ST_BOOT:
      begin
        if (flash_ready & osc_stable & ~dig_rst)
        begin
          next_r.st = ST_ACTIVE; // R16
        end
      end
      ST_ACTIVE:
      begin
        if (r.pctl[`PCS_B_BOFF] & ~fld_ok)
        begin
          next_r.st = ST_OFF; // R12
        end
        else if (r.pctl[`PCS_B_DPD])
        begin
          next_r.st = ST_DPD; // R13
        end
        else if (r.pctl[`PCS_B_SLEEP])
        begin
          next_r.st = ST_SLEEP; // R13
        end
        // Only requests already pending are cleared, so one newly written in this cycle survives.
        next_r.pctl = next_r.pctl & ~(r.pctl & `PCS_REQ_MASK);
      end
      ST_SLEEP:
      begin
        if (wake_ds)
        begin
          next_r.st = ST_ACTIVE; // R19
        end
      end
      ST_DPD:
      begin
        next_r.tcnt = 7'h00;
        if (wake_dpd)
        begin
          next_r.st = ST_DREG; // R20
        end
      end
      ST_OFF:
      begin
        next_r.bat_sw = 1'b0; // R12
        next_r.tcnt   = 7'h00;
        if ((reset_pin_active_low & ~r.pin_q) | fld_ok)
        begin
          next_r.bat_sw = 1'b1;
          next_r.st     = ST_IDLE; // R7
        end
      end
    endcase
    // Any digital reset source restores clocking and power flags.
    if (dig_rst)
    begin
      next_r.div_sel = `PCS_DIV_RESET; // R2 R26
      next_r.div_act = `PCS_DIV_RESET;
      next_r.div_cnt = 7'h00;
      next_r.gate    = `PCS_GATE_RESET; // R26
      next_r.pctl    = 8'h00; // R26
      next_r.remap   = 2'h0;
      if ((r.st == ST_ACTIVE) | (r.st == ST_SLEEP))
      begin
        next_r.st = ST_BOOT;
      end
    end
    // The battery switch is open from the very edge that enters battery-off.
    if (next_r.st == ST_OFF)
    begin
      next_r.bat_sw = 1'b0; // R12
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      r         <= '0;
      r.st      <= ST_IDLE;
      r.div_sel <= `PCS_DIV_RESET;
      r.div_act <= `PCS_DIV_RESET;
      r.gate    <= `PCS_GATE_RESET;
      r.use_bat <= 1'b1;
      r.pin_q   <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign rdata                  = r.rdata;
  assign sys_tick               = r.sys_tick;
  assign periph_tick            = r.gate & {16{r.sys_tick}}; // R4
  assign tsens_tick             = r.ts_tick; // R5
  assign battery_power_switch   = r.bat_sw & r.use_bat; // R8
  assign field_power_switch     = fld_ok & ~(r.bat_sw & r.use_bat); // R9 R18
  assign selector_comparator_en = ~r.pctl[`PCS_B_AUTODIS]; // R11
  assign digital_regulator_en   = (r.st != ST_IDLE) & (r.st != ST_DPD) & (r.st != ST_OFF); // R21
  assign analog_regulator_en    = digital_regulator_en & (r.st != ST_DREG); // R21
  assign sys_reset_n            = analog_regulator_en & osc_stable & ~dig_rst; // R16
  assign boot_enable            = (r.st == ST_ACTIVE); // R16
  assign deep_power_down_flag   = (r.st == ST_DPD); // R13
  assign sleep_flag             = (r.st == ST_SLEEP); // R13
  assign brownout_irq           = r.bod_irq;
  assign vector_remap           = r.remap;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_div_reset_default: assert property (dig_rst |=> r.div_sel == `PCS_DIV_RESET) // R2
    else $error("divider not restored by reset");
  a_div_no_glitch: assert property ($changed(r.div_act) && !$past(dig_rst) |-> r.sys_tick) // R25
    else $error("divider changed inside a period");
  a_gate_blocks: assert property ((|periph_tick) |-> sys_tick) // R4
    else $error("peripheral tick without system tick");
  a_force_battery: assert property (r.pctl[`PCS_B_AUTODIS] |-> !selector_comparator_en ##1 r.use_bat) // R11
    else $error("forced battery selection ignored");
  a_field_fallback: assert property (!battery_ok && field_present && !r.pctl[`PCS_B_AUTODIS] // R9
                                     |=> field_power_switch)
    else $error("field not used when battery low");
  a_dpd_regs_off: assert property (deep_power_down_flag |-> !digital_regulator_en && !analog_regulator_en // R13
                                   && !sleep_flag)
    else $error("regulators on in deep power-down");
  a_reg_order: assert property ($rose(analog_regulator_en) |-> $past(digital_regulator_en)) // R15
    else $error("analog regulator before digital");
  a_boot_flash: assert property ($rose(boot_enable) |-> $past(flash_ready) && $past(osc_stable)) // R16
    else $error("boot before flash ready");
  a_sw_reset: assert property (wr && addr == `PCS_OFS_SWRST && wdata[0] |=> !sys_reset_n) // R6
    else $error("software reset not applied");
  a_off_open: assert property (r.st == ST_OFF |-> !battery_power_switch) // R12
    else $error("battery switch closed in battery off");
  a_brownout: assert property (r.pctl[`PCS_B_BODEN] && always_on_low |=> brownout_irq) // R14
    else $error("brownout interrupt missing");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_areg_after_dreg: assert property ($rose(digital_regulator_en) |-> !analog_regulator_en) // R15
    else $error("analog regulator not after digital");
  a_release_order: assert property (sys_reset_n |-> digital_regulator_en && osc_stable) // R16
    else $error("digital reset released too early");
  a_reset_defaults: assert property (dig_rst |=> r.gate == `PCS_GATE_RESET && r.pctl == 8'h00) // R26
    else $error("gates or power flags not restored");
  a_battery_wins: assert property (battery_ok && !r.pctl[`PCS_B_AUTODIS] |=> r.use_bat) // R8
    else $error("battery not preferred");
  a_sleep_wake: assert property (sleep_flag && wake_ds && !dig_rst |=> boot_enable) // R19
    else $error("sleep wake event ignored");
  a_dpd_hold: assert property (deep_power_down_flag && !wake_dpd |=> deep_power_down_flag) // R20
    else $error("deep power-down left without wake event");
  a_dpd_wake: assert property (deep_power_down_flag && wake_dpd |=> digital_regulator_en) // R20
    else $error("deep power-down wake ignored");
  a_boff_refused: assert property (boot_enable && field_present |=> r.st != ST_OFF) // R12
    else $error("battery off entered with field present");
  a_req_clear: assert property (boot_enable && !wr |=> (r.pctl & `PCS_REQ_MASK) == 8'h00) // R13
    else $error("power request not cleared");

  c_reach_active: cover property ($rose(boot_enable));
  c_dpd_wake: cover property (deep_power_down_flag ##1 !deep_power_down_flag);
  c_sleep_wake: cover property (sleep_flag ##1 boot_enable);
  c_battery_off: cover property (r.st == ST_OFF);
  c_field_start: cover property (field_power_switch && $rose(digital_regulator_en));
endmodule

// ### verif/pcs_far_side.sv
`timescale 1ns/1ps
module pcs_far_side #(
  parameter int OSC_DIV  = 4,
  parameter int TMR_DIV  = 8,
  parameter int WAKE_LOW = 200
) (
  // Clock.
  input  wire logic clock,
  // Requests from the bench.
  input  wire logic bat_on,
  input  wire logic fld_on,
  input  wire logic wake_go,
  // Oscillator ticks, supply levels and pins toward the block.
  output logic      osc_tick,
  output logic      tmr_tick,
  output logic      battery_ok,
  output logic      field_present,
  output logic      external_wake_pin
);
  int oc = 0;
  int tc = 0;
  int wc = 0;
  always_ff @(posedge clock)
  begin
    oc <= (oc + 1) % OSC_DIV;
    tc <= (tc + 1) % TMR_DIV;
    wc <= wake_go ? WAKE_LOW : (wc > 0 ? wc - 1 : 0);
  end
  assign osc_tick = (oc == 0);
  assign tmr_tick = (tc == 0);
  assign battery_ok = bat_on;
  assign field_present = fld_on;
  // The wake pin idles high and is held low for a scaled minimum time.
  assign external_wake_pin = (wc == 0);
endmodule

// ### verif/power_clock_sequencer_bench.sv
`timescale 1ns/1ps
`include "pcs_defs.svh"
module power_clock_sequencer_bench import pcs_pkg::*;;
  logic        clock, rstn, wr, rd, osc_stable, flash_ready, reset_pin_active_low, wdt_reset_req;
  logic        always_on_low, rtc_match, wdt_event, start_irq, bat_on, fld_on, wake_go;
  logic        osc_tick, tmr_tick, battery_ok, field_present, external_wake_pin, sys_tick, tsens_tick;
  logic        battery_power_switch, field_power_switch, selector_comparator_en, digital_regulator_en;
  logic        analog_regulator_en, sys_reset_n, boot_enable, deep_power_down_flag, sleep_flag, brownout_irq;
  logic [7:0]  addr;
  logic [15:0] periph_tick;
  logic [1:0]  vector_remap;
  logic [31:0] wdata, rdata, v;
  int          n_fail = 0;
  int          compares = 0;
  int          n;

  pcs_far_side far_u (.clock, .bat_on, .fld_on, .wake_go, .osc_tick, .tmr_tick, .battery_ok,
    .field_present, .external_wake_pin);
  pcs_top dut_u (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .osc_tick, .tmr_tick, .osc_stable,
    .flash_ready, .reset_pin_active_low, .wdt_reset_req, .battery_ok, .field_present, .always_on_low,
    .rtc_match, .wdt_event, .external_wake_pin, .start_irq, .sys_tick, .periph_tick, .tsens_tick,
    .battery_power_switch, .field_power_switch, .selector_comparator_en, .digital_regulator_en,
    .analog_regulator_en, .sys_reset_n, .boot_enable, .deep_power_down_flag, .sleep_flag,
    .brownout_irq, .vector_remap);

  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1;
    v = rdata;
    if (nm != "") chk(nm, e, v);
  endtask

  task automatic wait_hi(ref logic s, input logic e);
    for (int i = 0; i < 4000 && s !== e; i++) step(1);
    if (s !== e)
    begin
      chk("wait", {31'h0, e}, {31'h0, s});
      final_report();
    end
  endtask

  task automatic gap(ref logic s);
    wait_hi(s, 1'b1);
    n = 0;
    do
    begin
      step(1);
      n++;
    end while (s !== 1'b1 && n < 3000);
    if (s !== 1'b1)
    begin
      chk("gap", 32'h0000_0001, {31'h0, s});
      final_report();
    end
  endtask

  task automatic pin_pulse;
    @(posedge clock) reset_pin_active_low <= 1'b0;
    @(posedge clock) reset_pin_active_low <= 1'b1;
    #1;
  endtask

  initial
  begin
    {wr, rd, wdt_reset_req, always_on_low, rtc_match, wdt_event, start_irq, fld_on, wake_go} = '0;
    {osc_stable, flash_ready, reset_pin_active_low, bat_on} = '1;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    rstn = 1'b0;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    step(1);
    rchk("div", `PCS_OFS_DIV, 32'h0000_0004);
    rchk("gate", `PCS_OFS_GATE, 32'h0000_001f);
    rchk("unmapped", 8'h18, 32'h0000_0000);
    step(40);
    chk("bat switch", 0, {31'h0, battery_power_switch});
    chk("dreg idle", 0, {31'h0, digital_regulator_en});
    $display("test defaults done");
    pin_pulse();
    wait_hi(digital_regulator_en, 1'b1);
    chk("bat switch", 1, {31'h0, battery_power_switch});
    chk("areg first", 0, {31'h0, analog_regulator_en});
    wait_hi(analog_regulator_en, 1'b1);
    wait_hi(boot_enable, 1'b1);
    chk("sys reset", 1, {31'h0, sys_reset_n});
    rchk("status", `PCS_OFS_STAT, 32'h0000_0786);
    $display("test startup done");
    for (int s = 0; s < 8; s++)
    begin
      wr_reg(`PCS_OFS_DIV, 32'(s));
      gap(sys_tick);
      gap(sys_tick);
      chk("sys period", 32'((1 << s) * 4), 32'(n));
    end
    gap(tsens_tick);
    gap(tsens_tick);
    chk("tsens period", 32'h0000_0020, 32'(n));
    wr_reg(`PCS_OFS_DIV, 32'h0000_0000);
    wr_reg(`PCS_OFS_GATE, 32'h0000_0005);
    wait_hi(sys_tick, 1'b1);
    chk("periph", 32'h0000_0005, {16'h0, periph_tick});
    step(1);
    chk("periph idle", 0, {16'h0, periph_tick});
    $display("test clocks done");
    wr_reg(`PCS_OFS_REMAP, 32'h0000_0002);
    chk("remap", 32'h0000_0002, {30'h0, vector_remap});
    for (int i = 0; i < 5; i++) wr_reg(8'(`PCS_OFS_RET0 + 4 * i), 32'h1234_0000 + 32'(i));
    wr_reg(`PCS_OFS_SWRST, 32'h0000_0001);
    step(2);
    rchk("div", `PCS_OFS_DIV, 32'h0000_0004);
    rchk("gate", `PCS_OFS_GATE, 32'h0000_001f);
    rchk("remap", `PCS_OFS_REMAP, 32'h0000_0000);
    for (int i = 0; i < 5; i++) rchk("ret", 8'(`PCS_OFS_RET0 + 4 * i), 32'h1234_0000 + 32'(i));
    wr_reg(`PCS_OFS_DIV, 32'h0000_0001);
    @(posedge clock) wdt_reset_req <= 1'b1;
    #1;
    chk("wdt reset", 0, {31'h0, sys_reset_n});
    @(posedge clock) wdt_reset_req <= 1'b0;
    rchk("div", `PCS_OFS_DIV, 32'h0000_0004);
    wr_reg(`PCS_OFS_DIV, 32'h0000_0003);
    pin_pulse();
    rchk("div", `PCS_OFS_DIV, 32'h0000_0004);
    $display("test resets done");
    step(5);
    wait_hi(boot_enable, 1'b1);
    wr_reg(`PCS_OFS_PCTL, 32'h0000_0001);
    wait_hi(sleep_flag, 1'b1);
    chk("sleep regs", 3, {30'h0, digital_regulator_en, analog_regulator_en});
    @(posedge clock) start_irq <= 1'b1;
    @(posedge clock) start_irq <= 1'b0;
    wait_hi(sleep_flag, 1'b0);
    wr_reg(`PCS_OFS_PCTL, 32'h0000_0022);
    wait_hi(deep_power_down_flag, 1'b1);
    step(2);
    chk("dpd regs", 0, {30'h0, digital_regulator_en, analog_regulator_en});
    @(posedge clock) start_irq <= 1'b1;
    @(posedge clock) start_irq <= 1'b0;
    step(20);
    chk("dpd hold", 1, {31'h0, deep_power_down_flag});
    @(posedge clock) wake_go <= 1'b1;
    @(posedge clock) wake_go <= 1'b0;
    wait_hi(digital_regulator_en, 1'b1);
    wait_hi(boot_enable, 1'b1);
    chk("dpd flag", 0, {31'h0, deep_power_down_flag});
    $display("test power states done");
    @(posedge clock) fld_on <= 1'b1;
    rchk("use bat", `PCS_OFS_STAT, 32'h0000_0786);
    chk("bat wins", 1, {31'h0, v[10]});
    @(posedge clock) bat_on <= 1'b0;
    step(3);
    rchk("", `PCS_OFS_STAT, 0);
    chk("to field", 0, {31'h0, v[10]});
    chk("field sw", 1, {31'h0, field_power_switch});
    @(posedge clock) bat_on <= 1'b1;
    step(3);
    rchk("", `PCS_OFS_STAT, 0);
    chk("back bat", 1, {31'h0, v[10]});
    @(posedge clock) bat_on <= 1'b0;
    wr_reg(`PCS_OFS_PCTL, 32'h0000_0008);
    step(3);
    rchk("", `PCS_OFS_STAT, 0);
    chk("forced bat", 1, {31'h0, v[10]});
    chk("comparator", 0, {31'h0, selector_comparator_en});
    @(posedge clock) always_on_low <= 1'b1;
    wr_reg(`PCS_OFS_PCTL, 32'h0000_0000);
    step(3);
    chk("bod off", 0, {31'h0, brownout_irq});
    wr_reg(`PCS_OFS_PCTL, 32'h0000_0010);
    step(3);
    chk("bod on", 1, {31'h0, brownout_irq});
    @(posedge clock) always_on_low <= 1'b0;
    @(posedge clock) bat_on <= 1'b1;
    wr_reg(`PCS_OFS_PCTL, 32'h0000_0004);
    step(5);
    chk("off refused", 1, {31'h0, battery_power_switch});
    @(posedge clock) fld_on <= 1'b0;
    wr_reg(`PCS_OFS_PCTL, 32'h0000_0004);
    wait_hi(battery_power_switch, 1'b0);
    @(posedge clock) bat_on <= 1'b0;
    @(posedge clock) fld_on <= 1'b1;
    wait_hi(digital_regulator_en, 1'b1);
    chk("field start", 1, {31'h0, field_power_switch});
    $display("test supplies done");
    final_report();
  end
endmodule
